//--- core/tfs_out_gate.sv
// One discrete profile output with segment, direction and polarity gating.
// Assumes profile flags come from registered state on the same clock.
`timescale 1ns/1ps
module tfs_out_gate (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] segmentSel,
    input wire logic [1:0] directionSel,
    input wire logic polarity,
    input wire logic inAccelDecel,
    input wire logic inPlateau,
    input wire logic inDwell,
    input wire logic travelFwd,
    output logic outPin
);
    logic segMatch;
    logic dirMatch;
    logic next_outPin;

    // Segment match, direction match, then polarity
    always_comb begin
        case (segmentSel)
            tfs_pkg::SEG_PLATEAU: segMatch = inPlateau; // R01 R05
            tfs_pkg::SEG_MOVING: segMatch = inPlateau | inAccelDecel; // R01
            tfs_pkg::SEG_DWELL: segMatch = inDwell; // R01 R05
            default: segMatch = 1'b0;
        endcase
        case (directionSel)
            tfs_pkg::DIR_FWD: dirMatch = travelFwd; // R02
            tfs_pkg::DIR_REV: dirMatch = ~travelFwd; // R02
            tfs_pkg::DIR_BOTH: dirMatch = 1'b1; // R02
            default: dirMatch = 1'b0;
        endcase
        next_outPin = (segMatch & dirMatch) ~^ polarity; // R03 R20
    end

    // Registered pin; reset shows inactive at default low-active polarity
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            outPin <= 1'b1;
        end else begin
            outPin <= next_outPin;
        end
    end

    AST_OUT_POLARITY: assert property (@(posedge clk) disable iff (sys_rst) // R03
        (segMatch & dirMatch) |=> (outPin == $past(polarity)))
        else $error("Output not at active level after match");
    AST_OUT_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // R20
        !(segMatch & dirMatch) |=> (outPin == !$past(polarity)))
        else $error("Output active without match");
endmodule

//--- core/tfs_pkg.sv
// Constants, settings codes and state types for the traverse follower sequencer.
// Assumes a single 25 MHz clock domain and a plain register port with one-cycle read data.
//
// Notes on behaviour
// R01: Output B segment code 1 plateau, 2 plateau plus ramps, 3 dwell only.
// R02: Output B direction code 1 forward, 2 reverse, 3 both.
// R03: Output B polarity 0 drives active low, 1 drives active high.
// R04: Reset defaults for output B: segment 1, direction 0, polarity 0.
// R05: Output A has its own segment, direction and polarity with B's codes.
// R06: Run starts follower mode only with control mode 1 or 3.
// R07: Start is accepted only from fast-stop or position hold.
// R08: Start is refused unless position lies inside the at-home band.
// R09: Start is allowed only while the profile validity monitor reads zero.
// R10: Follower motion begins at home travelling forward.
// R11: Each pass ramps up, holds ratio on plateau, ramps down into dwell.
// R12: Dwell at zero speed, then repeat the pass reversed, forever.
// R13: Wait low pauses at the nearest profile end until wait returns high.
// R14: Drive enable stays asserted throughout follower mode.
// R15: Home set loads current position as home, making position zero.
// R16: Home set is a momentary edge-triggered request.
// R17: Home set also asserts drive enable to hold the axis at home.
// R18: Follower mode is refused until a home has been established.
// R19: At-home band is encoder lines either side of zero home.
// R20: Output active when segment and direction match, polarity applied last.
package tfs_pkg;
    localparam int POS_W = 24;
    localparam int LEN_W = 24;
    // Register indices on the plain port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OUT_A = 4'h1;
    localparam logic [3:0] ADDR_OUT_B = 4'h2;
    localparam logic [3:0] ADDR_BAND = 4'h3;
    localparam logic [3:0] ADDR_RAMP = 4'h4;
    localparam logic [3:0] ADDR_DWELL = 4'h5;
    localparam logic [3:0] ADDR_LEN1 = 4'h6;
    localparam logic [3:0] ADDR_LEN2 = 4'h7;
    localparam logic [3:0] ADDR_LEN3 = 4'h8;
    localparam logic [3:0] ADDR_LEN4 = 4'h9;
    localparam logic [3:0] ADDR_STATUS = 4'hA;
    localparam logic [3:0] ADDR_POS = 4'hB;
    // Output settings field layout: [1:0] segment, [3:2] direction, [4] polarity
    localparam int SEG_LSB = 0;
    localparam int DIR_LSB = 2;
    localparam int POL_BIT = 4;
    // Control field layout: [1:0] control mode, [3:2] traverse length select
    localparam int MODE_LSB = 0;
    localparam int LSEL_LSB = 2;
    // Reset values
    localparam logic [1:0] SEG_RESET = 2'h1;
    localparam logic [1:0] DIR_RESET = 2'h0;
    localparam logic POL_RESET = 1'b0;
    localparam logic [1:0] MODE_RESET = 2'h1;
    localparam logic [LEN_W-1:0] BAND_RESET = 24'h00_0004;
    localparam logic [LEN_W-1:0] RAMP_RESET = 24'h00_0010;
    localparam logic [LEN_W-1:0] DWELL_RESET = 24'h00_0010;
    localparam logic [LEN_W-1:0] LEN_RESET = 24'h00_0100;
    // Codes
    localparam logic [1:0] MODE_STANDARD = 2'h1;
    localparam logic [1:0] MODE_LAY_ADJ = 2'h3;
    localparam logic [1:0] SEG_PLATEAU = 2'h1;
    localparam logic [1:0] SEG_MOVING = 2'h2;
    localparam logic [1:0] SEG_DWELL = 2'h3;
    localparam logic [1:0] DIR_FWD = 2'h1;
    localparam logic [1:0] DIR_REV = 2'h2;
    localparam logic [1:0] DIR_BOTH = 2'h3;
    // Sequencer states, Gray coded along the pass
    typedef enum logic [2:0] {
        ST_STOP = 3'b000,
        ST_ACCEL = 3'b001,
        ST_PLATEAU = 3'b011,
        ST_DECEL = 3'b010,
        ST_DWELL = 3'b110,
        ST_HOLD = 3'b111
    } tfs_state_type;
endpackage

//--- core/traverse_follower_sequencer.sv
// Traverse follower sequencer: start checks, pass profile, wait, home set, outputs A and B.
// Assumes encoder position and operator pins are asynchronous to clk; settings via plain port.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module traverse_follower_sequencer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    input wire logic runIn,
    input wire logic fastStopIn,
    input wire logic waitIn,
    input wire logic homeSetIn,
    input wire logic profileValidMonitor,
    input wire logic [23:0] encoderCount,
    output logic driveEnable,
    output logic travelFwd,
    output logic [1:0] speedSegment,
    output logic outA,
    output logic outB
);
    localparam int PW = tfs_pkg::POS_W;
    localparam int LW = tfs_pkg::LEN_W;

    // Settings
    logic [1:0] controlModeSel;
    logic [1:0] lengthSel;
    logic [1:0] outASegmentSel, outADirectionSel, outBSegmentSel, outBDirectionSel;
    logic outAPolarity, outBPolarity;
    logic [LW-1:0] homeToleranceBand, rampLength, dwellSetting;
    logic [LW-1:0] traverseLength [4];

    // Synchronisers
    logic [1:0] runMeta, stopMeta, waitMeta, homeMeta, validMeta;
    logic runSync, stopSync, waitSync, homeSync, homeSyncD, validSync;
    logic [PW-1:0] encMeta, encSync;

    // Position and sequencer state
    logic [PW-1:0] homeOffset, followerPos;
    logic homeValid, holdActive;
    tfs_pkg::tfs_state_type state;
    logic [LW-1:0] passCount, dwellCount;
    logic [LW-1:0] selLength;
    logic startOk, homeEdge, paused, inBand;
    logic [31:0] next_regRdData;

    // Two-stage synchronisers; only the second stage feeds logic
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            runMeta <= 2'b00;
            stopMeta <= 2'b00;
            waitMeta <= 2'b11;
            homeMeta <= 2'b00;
            validMeta <= 2'b11;
            encMeta <= '0;
            encSync <= '0;
            homeSyncD <= 1'b0;
        end else begin
            runMeta <= {runMeta[0], runIn};
            stopMeta <= {stopMeta[0], fastStopIn};
            waitMeta <= {waitMeta[0], waitIn};
            homeMeta <= {homeMeta[0], homeSetIn};
            validMeta <= {validMeta[0], profileValidMonitor};
            encMeta <= encoderCount;
            encSync <= encMeta;
            homeSyncD <= homeSync;
        end
    end
    assign runSync = runMeta[1];
    assign stopSync = stopMeta[1];
    assign waitSync = waitMeta[1];
    assign homeSync = homeMeta[1];
    assign validSync = validMeta[1];
    assign homeEdge = homeSync & ~homeSyncD; // R16

    // Follower position relative to home; band test on both sides of zero
    assign followerPos = encSync - homeOffset; // R15
    assign inBand = ($signed(followerPos) <= $signed(homeToleranceBand))
        && ($signed(followerPos) >= -$signed(homeToleranceBand)); // R19 R08
    assign selLength = traverseLength[lengthSel];
    assign startOk = runSync
        && ((controlModeSel == tfs_pkg::MODE_STANDARD)
            || (controlModeSel == tfs_pkg::MODE_LAY_ADJ)) // R06
        && ((state == tfs_pkg::ST_STOP) || (state == tfs_pkg::ST_HOLD)) // R07
        && inBand // R08
        && !validSync // R09
        && homeValid; // R18
    assign paused = !waitSync; // R13

    // Settings registers written over the plain port
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            controlModeSel <= tfs_pkg::MODE_RESET;
            lengthSel <= 2'h0;
            outASegmentSel <= tfs_pkg::SEG_RESET;
            outADirectionSel <= tfs_pkg::DIR_RESET;
            outAPolarity <= tfs_pkg::POL_RESET;
            outBSegmentSel <= tfs_pkg::SEG_RESET; // R04
            outBDirectionSel <= tfs_pkg::DIR_RESET; // R04
            outBPolarity <= tfs_pkg::POL_RESET; // R04
            homeToleranceBand <= tfs_pkg::BAND_RESET;
            rampLength <= tfs_pkg::RAMP_RESET;
            dwellSetting <= tfs_pkg::DWELL_RESET;
            for (int i = 0; i < 4; i++) begin
                traverseLength[i] <= tfs_pkg::LEN_RESET;
            end
        end else if (regWrite) begin
            case (regAddr)
                tfs_pkg::ADDR_CTRL: begin
                    controlModeSel <= regWrData[tfs_pkg::MODE_LSB +: 2];
                    lengthSel <= regWrData[tfs_pkg::LSEL_LSB +: 2];
                end
                tfs_pkg::ADDR_OUT_A: begin
                    outASegmentSel <= regWrData[tfs_pkg::SEG_LSB +: 2]; // R05
                    outADirectionSel <= regWrData[tfs_pkg::DIR_LSB +: 2];
                    outAPolarity <= regWrData[tfs_pkg::POL_BIT];
                end
                tfs_pkg::ADDR_OUT_B: begin
                    outBSegmentSel <= regWrData[tfs_pkg::SEG_LSB +: 2];
                    outBDirectionSel <= regWrData[tfs_pkg::DIR_LSB +: 2];
                    outBPolarity <= regWrData[tfs_pkg::POL_BIT];
                end
                tfs_pkg::ADDR_BAND: homeToleranceBand <= regWrData[LW-1:0];
                tfs_pkg::ADDR_RAMP: rampLength <= regWrData[LW-1:0];
                tfs_pkg::ADDR_DWELL: dwellSetting <= regWrData[LW-1:0];
                tfs_pkg::ADDR_LEN1: traverseLength[0] <= regWrData[LW-1:0];
                tfs_pkg::ADDR_LEN2: traverseLength[1] <= regWrData[LW-1:0];
                tfs_pkg::ADDR_LEN3: traverseLength[2] <= regWrData[LW-1:0];
                tfs_pkg::ADDR_LEN4: traverseLength[3] <= regWrData[LW-1:0];
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe, zero elsewhere
    always_comb begin
        next_regRdData = 32'h0000_0000;
        if (regRead) begin
            case (regAddr)
                tfs_pkg::ADDR_CTRL: next_regRdData = {28'h000_0000, lengthSel, controlModeSel};
                tfs_pkg::ADDR_OUT_A: next_regRdData = {27'h000_0000, outAPolarity,
                    outADirectionSel, outASegmentSel};
                tfs_pkg::ADDR_OUT_B: next_regRdData = {27'h000_0000, outBPolarity,
                    outBDirectionSel, outBSegmentSel};
                tfs_pkg::ADDR_BAND: next_regRdData = {8'h00, homeToleranceBand};
                tfs_pkg::ADDR_RAMP: next_regRdData = {8'h00, rampLength};
                tfs_pkg::ADDR_DWELL: next_regRdData = {8'h00, dwellSetting};
                tfs_pkg::ADDR_LEN1: next_regRdData = {8'h00, traverseLength[0]};
                tfs_pkg::ADDR_LEN2: next_regRdData = {8'h00, traverseLength[1]};
                tfs_pkg::ADDR_LEN3: next_regRdData = {8'h00, traverseLength[2]};
                tfs_pkg::ADDR_LEN4: next_regRdData = {8'h00, traverseLength[3]};
                tfs_pkg::ADDR_STATUS: next_regRdData = {24'h00_0000, paused, inBand,
                    homeValid, travelFwd, driveEnable, state};
                tfs_pkg::ADDR_POS: next_regRdData = {8'h00, followerPos};
                default: next_regRdData = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 32'h0000_0000;
        end else begin
            regRdData <= next_regRdData;
        end
    end

    // Next-state logic for the pass profile
    tfs_pkg::tfs_state_type next_state;
    logic [LW-1:0] next_passCount, next_dwellCount;
    logic next_travelFwd, next_homeValid, next_holdActive;
    logic [PW-1:0] next_homeOffset;
    always_comb begin
        next_state = state;
        next_passCount = passCount;
        next_dwellCount = dwellCount;
        next_travelFwd = travelFwd;
        next_homeValid = homeValid;
        next_holdActive = holdActive;
        next_homeOffset = homeOffset;
        if (homeEdge && (state == tfs_pkg::ST_STOP || state == tfs_pkg::ST_HOLD)) begin
            next_homeOffset = encSync; // R15
            next_homeValid = 1'b1; // R18
            next_holdActive = 1'b1; // R17
            next_state = tfs_pkg::ST_HOLD;
        end
        if (stopSync) begin
            next_state = tfs_pkg::ST_STOP;
            next_holdActive = 1'b0;
        end else begin
            case (state)
                tfs_pkg::ST_STOP, tfs_pkg::ST_HOLD: begin
                    if (startOk && !homeEdge) begin
                        next_state = tfs_pkg::ST_ACCEL;
                        next_travelFwd = 1'b1; // R10
                        next_passCount = '0;
                    end
                end
                tfs_pkg::ST_ACCEL: begin
                    next_passCount = passCount + 1'b1;
                    if (passCount + 1'b1 >= rampLength) begin
                        next_state = tfs_pkg::ST_PLATEAU; // R11
                    end
                end
                tfs_pkg::ST_PLATEAU: begin
                    next_passCount = passCount + 1'b1;
                    if (passCount + 1'b1 >= selLength - rampLength) begin
                        next_state = tfs_pkg::ST_DECEL; // R11
                    end
                end
                tfs_pkg::ST_DECEL: begin
                    next_passCount = passCount + 1'b1;
                    if (passCount + 1'b1 >= selLength) begin
                        next_state = tfs_pkg::ST_DWELL; // R11
                        next_dwellCount = '0;
                    end
                end
                tfs_pkg::ST_DWELL: begin
                    if (dwellCount < dwellSetting) begin
                        next_dwellCount = dwellCount + 1'b1;
                    end else if (!paused) begin
                        next_state = tfs_pkg::ST_ACCEL; // R12 R13
                        next_travelFwd = ~travelFwd; // R12
                        next_passCount = '0;
                    end
                end
                default: next_state = tfs_pkg::ST_STOP;
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= tfs_pkg::ST_STOP;
            passCount <= '0;
            dwellCount <= '0;
            travelFwd <= 1'b1;
            homeValid <= 1'b0;
            holdActive <= 1'b0;
            homeOffset <= '0;
        end else begin
            state <= next_state;
            passCount <= next_passCount;
            dwellCount <= next_dwellCount;
            travelFwd <= next_travelFwd;
            homeValid <= next_homeValid;
            holdActive <= next_holdActive;
            homeOffset <= next_homeOffset;
        end
    end

    // Drive enable and speed segment to the drive
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            driveEnable <= 1'b0;
            speedSegment <= 2'h0;
        end else begin
            driveEnable <= (next_state != tfs_pkg::ST_STOP) || next_holdActive; // R14 R17
            case (next_state)
                tfs_pkg::ST_ACCEL: speedSegment <= 2'h1;
                tfs_pkg::ST_PLATEAU: speedSegment <= 2'h2;
                tfs_pkg::ST_DECEL: speedSegment <= 2'h3;
                default: speedSegment <= 2'h0;
            endcase
        end
    end

    // Profile output A
    tfs_out_gate outAGate (
        .clk(clk),
        .sys_rst(sys_rst),
        .segmentSel(outASegmentSel),
        .directionSel(outADirectionSel),
        .polarity(outAPolarity),
        .inAccelDecel(state == tfs_pkg::ST_ACCEL || state == tfs_pkg::ST_DECEL),
        .inPlateau(state == tfs_pkg::ST_PLATEAU),
        .inDwell(state == tfs_pkg::ST_DWELL),
        .travelFwd(travelFwd),
        .outPin(outA)
    );

    // Profile output B
    tfs_out_gate outBGate (
        .clk(clk),
        .sys_rst(sys_rst),
        .segmentSel(outBSegmentSel),
        .directionSel(outBDirectionSel),
        .polarity(outBPolarity),
        .inAccelDecel(state == tfs_pkg::ST_ACCEL || state == tfs_pkg::ST_DECEL),
        .inPlateau(state == tfs_pkg::ST_PLATEAU),
        .inDwell(state == tfs_pkg::ST_DWELL),
        .travelFwd(travelFwd),
        .outPin(outB)
    );


    // A start out of stop or hold needs an established home
    AST_START_NEEDS_HOME: assert property (@(posedge clk) disable iff (sys_rst) // R18
        ($past(state) inside {tfs_pkg::ST_STOP, tfs_pkg::ST_HOLD}
            && state == tfs_pkg::ST_ACCEL) |-> homeValid)
        else $error("Follower started without home");

    // First pass after a start runs forward
    AST_START_FORWARD: assert property (@(posedge clk) disable iff (sys_rst) // R10
        (startOk && !stopSync && !homeEdge) |=> (state == tfs_pkg::ST_ACCEL && travelFwd))
        else $error("Start did not begin forward");

    // Start only in a follower control mode
    AST_START_MODE: assert property (@(posedge clk) disable iff (sys_rst) // R06
        ($past(state) inside {tfs_pkg::ST_STOP, tfs_pkg::ST_HOLD}
            && state == tfs_pkg::ST_ACCEL)
        |-> ($past(controlModeSel) == tfs_pkg::MODE_STANDARD
            || $past(controlModeSel) == tfs_pkg::MODE_LAY_ADJ))
        else $error("Start allowed in wrong mode");

    // Start only inside the home band with a valid profile
    AST_START_BAND: assert property (@(posedge clk) disable iff (sys_rst) // R08 R09
        ($past(state) inside {tfs_pkg::ST_STOP, tfs_pkg::ST_HOLD}
            && state == tfs_pkg::ST_ACCEL)
        |-> ($past(inBand) && !$past(validSync)))
        else $error("Start allowed outside band or without profile");

    // Drive stays enabled on the plateau
    AST_DRIVE_EN: assert property (@(posedge clk) disable iff (sys_rst) // R14
        (state == tfs_pkg::ST_PLATEAU) |-> driveEnable)
        else $error("Drive enable low in follower mode");

    // Holding at home keeps the drive enabled
    AST_HOLD_ENABLE: assert property (@(posedge clk) disable iff (sys_rst) // R17
        (state == tfs_pkg::ST_HOLD) |-> driveEnable)
        else $error("Drive enable low while holding home");

    // Home set loads the current position as offset
    AST_HOME_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // R15
        (homeEdge && !stopSync && state == tfs_pkg::ST_STOP)
        |=> (homeOffset == $past(encSync)) ##1 driveEnable)
        else $error("Home set did not load position");

    // Every dwell that goes on into a new pass ends in a reversal
    AST_DWELL_REVERSE: assert property (@(posedge clk) disable iff (sys_rst) // R12
        (state == tfs_pkg::ST_DWELL && !stopSync) ##1 (state == tfs_pkg::ST_ACCEL)
        |-> (travelFwd != $past(travelFwd)))
        else $error("Direction not reversed after dwell");

    // Wait low keeps the axis in dwell
    AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R13
        (state == tfs_pkg::ST_DWELL && paused) |=> (state != tfs_pkg::ST_ACCEL))
        else $error("Left dwell while wait low");
endmodule

//--- verification/tb.sv
// Self-checking bench: start conditions, pass profile, wait, home set, outputs A and B.
// Assumes the drive model closes the encoder loop and settings sit on the plain port.
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWrite = 1'b0, regRead = 1'b0, runIn = 1'b0, fastStopIn = 1'b0, waitIn = 1'b1;
    logic homeSetIn = 1'b0, pvm = 1'b0, nudgeStb = 1'b0;
    logic [23:0] nudge = 24'h0, encoderCount;
    logic [31:0] regRdData;
    logic driveEnable, travelFwd, outA, outB;
    logic [1:0] speedSegment, prevSeg;
    logic [4:0] cfgA = 5'h01, cfgB = 5'h01;
    logic lastFwd, prevFwd;
    int err_count = 0, n_compared = 0, runLen, quiet = 0, ramp = 4, len = 20, dwl = 6;
    bit mon = 0, armed = 0, lenChk = 1;
    traverse_follower_sequencer u_traverse_follower_sequencer (.clk(clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .runIn(runIn), .fastStopIn(fastStopIn), .waitIn(waitIn),
        .homeSetIn(homeSetIn), .profileValidMonitor(pvm), .encoderCount(encoderCount),
        .driveEnable(driveEnable), .travelFwd(travelFwd), .speedSegment(speedSegment),
        .outA(outA), .outB(outB));
    tfs_drive_model u_tfs_drive_model (.clk(clk), .driveEnable(driveEnable),
        .travelFwd(travelFwd), .speedSegment(speedSegment), .nudge(nudge),
        .nudgeStb(nudgeStb), .encoderCount(encoderCount));
    // Clock at 25 MHz
    always #20 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        quiet = 3;
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        quiet = 3;
    endtask
    task automatic rdc(input string n, input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(n, e, regRdData);
    endtask
    task automatic pulse(input bit home, input logic [23:0] d);
        @(posedge clk);
        nudge <= d;
        nudgeStb <= !home;
        homeSetIn <= home;
        @(posedge clk);
        nudgeStb <= 1'b0;
        homeSetIn <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic waitFor(input logic [1:0] s);
        int i;
        for (i = 0; i < 300 && speedSegment !== s; i++) @(posedge clk);
        if (i == 300) chk("segment wait", 32'h0, 32'h1);
    endtask
    task automatic tryStart(input bit ok);
        @(posedge clk);
        runIn <= 1'b1;
        armed = 1;
        repeat (12) @(posedge clk);
        armed = 0;
        chk("start", {31'h0, ok}, {31'h0, mon});
        if (!ok) runIn <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic expOut(input logic [4:0] c, input logic [1:0] s, input logic f);
        logic sg, dr;
        sg = (c[1:0] == tfs_pkg::SEG_PLATEAU && s == 2'h2) || (c[1:0] == tfs_pkg::SEG_MOVING
            && s != 2'h0) || (c[1:0] == tfs_pkg::SEG_DWELL && s == 2'h0);
        dr = (c[3:2] == tfs_pkg::DIR_FWD && f) || (c[3:2] == tfs_pkg::DIR_REV && !f)
            || c[3:2] == tfs_pkg::DIR_BOTH;
        return c[4] ? (sg && dr) : !(sg && dr);
    endfunction
    function automatic logic [31:0] expLen(input logic [1:0] s);
        return (s == 2'h2) ? len - 2 * ramp : (s == 2'h0) ? dwl + 1 : ramp;
    endfunction
    // Profile monitor: segment lengths, direction flips, drive enable and both outputs
    always @(negedge clk) begin
        if (!mon && armed && speedSegment === 2'h1) begin
            mon = 1;
            runLen = 1;
            prevSeg = 2'h1;
            lastFwd = travelFwd;
            prevFwd = travelFwd;
            chk("first direction", 32'h1, {31'h0, travelFwd});
        end else if (mon) begin
            chk("driveEnable", 32'h1, {31'h0, driveEnable});
            if (quiet > 0) quiet--;
            else begin
                chk("outA", {31'h0, expOut(cfgA, prevSeg, prevFwd)}, {31'h0, outA});
                chk("outB", {31'h0, expOut(cfgB, prevSeg, prevFwd)}, {31'h0, outB});
            end
            if (speedSegment != prevSeg) begin
                if (lenChk) chk("segment length", expLen(prevSeg), runLen);
                if (prevSeg == 2'h0) chk("reversal", {31'h0, !lastFwd}, {31'h0, travelFwd});
                if (prevSeg == 2'h0) lastFwd = travelFwd;
                runLen = 1;
            end else runLen++;
            prevSeg = speedSegment;
            prevFwd = travelFwd;
        end
    end
    // Watchdog sized well beyond the expected several hundred cycles
    initial begin
        #1600000;
        err_count++;
        close_out();
    end
    // Main sequence
    initial begin
        void'($urandom(18));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rdc("outB reset", tfs_pkg::ADDR_OUT_B, 32'h0000_0001);
        rdc("outA reset", tfs_pkg::ADDR_OUT_A, 32'h0000_0001);
        rdc("unmapped", 4'hC, 32'h0000_0000);
        wr(tfs_pkg::ADDR_RAMP, 32'h0000_0004);
        wr(tfs_pkg::ADDR_DWELL, 32'h0000_0006);
        wr(tfs_pkg::ADDR_LEN1, 32'h0000_0028);
        wr(tfs_pkg::ADDR_LEN2, 32'h0000_0014);
        wr(tfs_pkg::ADDR_CTRL, 32'h0000_0005);
        tryStart(0);
        pulse(0, 24'($urandom_range(16'hFFFF)));
        pulse(1, 24'h0);
        chk("hold enable", 32'h1, {31'h0, driveEnable});
        rdc("position", tfs_pkg::ADDR_POS, 32'h0000_0000);
        pulse(0, 24'h00_0005);
        tryStart(0);
        pulse(0, 24'hFF_FFFF);
        wr(tfs_pkg::ADDR_CTRL, 32'h0000_0006);
        tryStart(0);
        wr(tfs_pkg::ADDR_CTRL, 32'h0000_0005);
        pvm <= 1'b1;
        tryStart(0);
        pvm <= 1'b0;
        tryStart(1);
        for (int k = 0; k < 12; k++) begin
            waitFor(2'h0);
            cfgB = {1'($urandom_range(1)), 2'(k / 3), 2'(k % 3 + 1)};
            cfgA = 5'($urandom_range(31));
            wr(tfs_pkg::ADDR_OUT_B, {27'h0, cfgB});
            wr(tfs_pkg::ADDR_OUT_A, {27'h0, cfgA});
            waitFor(2'h1);
        end
        waitIn <= 1'b0;
        lenChk = 0;
        waitFor(2'h0);
        repeat (dwl + 30) @(posedge clk);
        chk("paused", 32'h0, {30'h0, speedSegment});
        waitIn <= 1'b1;
        waitFor(2'h1);
        lenChk = 1;
        waitFor(2'h0);
        mon = 0;
        fastStopIn <= 1'b1;
        runIn <= 1'b0;
        repeat (6) @(posedge clk);
        chk("stopped", 32'h0, {31'h0, driveEnable});
        fastStopIn <= 1'b0;
        pulse(1, 24'h0);
        wr(tfs_pkg::ADDR_CTRL, 32'h0000_0007);
        tryStart(1);
        waitFor(2'h0);
        waitFor(2'h1);
        waitFor(2'h0);
        close_out();
    end
endmodule

//--- verification/tfs_drive_model.sv
// Drive and encoder stand-in: position steps one line per cycle while the axis moves.
// Assumes speedSegment, travelFwd and driveEnable are registered on clk.
`timescale 1ns/1ps
module tfs_drive_model (
    input wire logic clk,
    input wire logic driveEnable,
    input wire logic travelFwd,
    input wire logic [1:0] speedSegment,
    input wire logic [23:0] nudge,
    input wire logic nudgeStb,
    output logic [23:0] encoderCount
);
    initial encoderCount = 24'h00_1234;
    // Integrate motion; a nudge stands for moving the mechanism by hand
    always @(posedge clk) begin
        if (nudgeStb) begin
            encoderCount <= encoderCount + nudge;
        end else if (driveEnable && speedSegment != 2'h0) begin
            encoderCount <= travelFwd ? encoderCount + 24'h00_0001 : encoderCount - 24'h00_0001;
        end
    end
endmodule
